// *** verilog/clpe_map.vh ***
// Constants for the integer execute slice: opcodes, functions, hints, fetch classes, status reset value
// Assumes plain Verilog-2005 and inclusion by bare name
`ifndef CLPE_MAP_VH
`define CLPE_MAP_VH
`define CLPE_OP_SPECIAL      6'h00
`define CLPE_OP_IMM_OR       6'h0d
`define CLPE_OP_SYSCOP       6'h10
`define CLPE_OP_ADV_FETCH    6'h33
`define CLPE_OP_BYTE_STORE   6'h28
`define CLPE_FN_NOR          6'h27
`define CLPE_FN_OR           6'h25
`define CLPE_FN_UMUL         6'h19
`define CLPE_FN_MFTOP        6'h10
`define CLPE_FN_MFBOT        6'h12
`define CLPE_FN_RESTORE      6'h10
`define CLPE_HINT_LOAD       5'h00
`define CLPE_HINT_STORE      5'h01
`define CLPE_HINT_LD_STREAM  5'h04
`define CLPE_HINT_ST_STREAM  5'h05
`define CLPE_HINT_LD_RETAIN  5'h06
`define CLPE_HINT_ST_RETAIN  5'h07
`define CLPE_HINT_IGN_HIT    5'h1f
`define CLPE_CLASS_NORMAL    2'h0
`define CLPE_CLASS_STREAM    2'h1
`define CLPE_CLASS_RETAIN    2'h2
`define CLPE_CLASS_REFILL    2'h3
`define CLPE_STATUS_RESET    32'h0000_0000
`define CLPE_MUL_CYCLES      6'h20
`endif

// *** verilog/clpe_exec.v ***
// Execute slice for unsigned multiply, NOR, OR, OR-immediate, advance fetch,
// exception restore and byte store.
// Assumes instructions arrive on clk, with register operands already read.
//
// Function
// - Unsigned multiply forms a 64-bit product into bottom and top product words
// - Product reads stall until a running multiply has written its result
// - Multiply never raises an overflow exception
// - Function 100111 writes NOR of both sources to the destination register
// - Register OR writes inclusive OR of both sources to the destination
// - Immediate OR zero-extends immediate, ORs with source a, writes field b
// - Advance fetch address is base plus sign-extended 16-bit offset
// - Advance fetch changes no visible state
// - Advance fetch suppresses addressing exceptions and then fetches nothing
// - Advance fetch never issues an operation to an uncached location
// - Advance fetch uses the access type of its effective address
// - Hint 0 fetches as for load, hint 1 as for store
// - With SHORT_HINTS 0, hints 4 and 5 fetch load/store as streamed, sparing retained data
// - With SHORT_HINTS 0, hints 6 and 7 fetch load/store as retained, not displaced by streamed
// - Short-table variant: hint 31 kernel only, invalidates and refills line
// - Reserved hints perform the default load-style fetch
// - Mapped fetch only proceeds when translation is already present
// - Exception restore shifts previous to current, old to previous; old kept
// - Exception restore raises reserved instruction where not implemented
// - Byte store writes low byte of source b at base plus sign-extended offset
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "clpe_map.vh"
module clpe_exec #(
    parameter HAS_RESTORE    = 1,
    parameter SHORT_HINTS    = 0,
    parameter MUL_CYCLES     = 32
) (
    // Clock and reset
    input  wire        clk,
    input  wire        srst,
    // Issued instruction and operands
    input  wire        instr_valid,
    input  wire [31:0] instr_word,
    input  wire [31:0] source_a_value,
    input  wire [31:0] source_b_value,
    input  wire        kernel_mode,
    // Translation answer for the effective address
    input  wire        xlat_mapped,
    input  wire        xlat_present,
    input  wire        xlat_uncached,
    input  wire        xlat_addr_error,
    // Stall to issue stage
    output wire        issue_stall,
    // General register write-back
    output reg         gr_we,
    output reg  [4:0]  gr_waddr,
    output reg  [31:0] gr_wdata,
    // Product words
    output reg  [31:0] product_bottom_word,
    output reg  [31:0] product_top_word,
    output wire        mul_busy,
    // Status word
    output reg  [31:0] status_word_reg,
    output reg         link_flag,
    // Exception report
    output reg         reserved_instr_exc,
    // Store port
    output reg         store_req,
    output reg  [31:0] store_addr,
    output reg  [31:0] store_data,
    output reg  [3:0]  store_byte_en,
    // Advance fetch port
    output reg         fetch_req,
    output reg  [31:0] fetch_addr,
    output reg         fetch_for_store,
    output reg  [1:0]  fetch_class,
    output reg         fetch_uncached
);
    wire [5:0]  opcode = instr_word[31:26];
    wire [4:0]  source_a_field = instr_word[25:21];
    wire [4:0]  source_b_field = instr_word[20:16];
    wire [4:0]  dest_field = instr_word[15:11];
    wire [5:0]  funct = instr_word[5:0];
    wire [15:0] imm = instr_word[15:0];
    wire [31:0] eff_addr = source_a_value + {{16{imm[15]}}, imm};

    wire is_special = opcode == `CLPE_OP_SPECIAL;
    wire is_nor     = is_special && funct == `CLPE_FN_NOR;
    wire is_or      = is_special && funct == `CLPE_FN_OR;
    wire is_umul    = is_special && funct == `CLPE_FN_UMUL;
    wire is_mftop   = is_special && funct == `CLPE_FN_MFTOP;
    wire is_mfbot   = is_special && funct == `CLPE_FN_MFBOT;
    wire is_ori     = opcode == `CLPE_OP_IMM_OR;
    wire is_fetch   = opcode == `CLPE_OP_ADV_FETCH;
    wire is_bstore  = opcode == `CLPE_OP_BYTE_STORE;
    wire is_restore = opcode == `CLPE_OP_SYSCOP && instr_word[25]
                      && funct == `CLPE_FN_RESTORE;

    // Iterative shift-add multiplier
    reg  [5:0]  mul_cnt_reg;
    reg  [31:0] mul_mcand_reg;
    reg  [63:0] mul_acc_reg;
    reg  [5:0]  mul_cnt_next;
    reg  [63:0] mul_acc_next;
    wire        mul_run = mul_cnt_reg != 6'h00;
    assign mul_busy = mul_run;

    // Product reads wait for a running multiply
    wire mf_wait = instr_valid && (is_mftop || is_mfbot) && mul_run;
    assign issue_stall = mf_wait;
    wire take = instr_valid && !mf_wait;

    // Hint decode
    reg       hint_ok;
    reg       hint_store;
    reg [1:0] hint_class;
    always @* begin
        hint_ok = 1'b1;
        hint_store = 1'b0;
        hint_class = `CLPE_CLASS_NORMAL;
        case (source_b_field)
            `CLPE_HINT_LOAD: hint_store = 1'b0;
            `CLPE_HINT_STORE: hint_store = 1'b1;
            `CLPE_HINT_LD_STREAM: begin
                if (SHORT_HINTS == 0)
                    hint_class = `CLPE_CLASS_STREAM;
            end
            `CLPE_HINT_ST_STREAM: begin
                if (SHORT_HINTS == 0) begin
                    hint_store = 1'b1;
                    hint_class = `CLPE_CLASS_STREAM;
                end
            end
            `CLPE_HINT_LD_RETAIN: begin
                if (SHORT_HINTS == 0)
                    hint_class = `CLPE_CLASS_RETAIN;
            end
            `CLPE_HINT_ST_RETAIN: begin
                if (SHORT_HINTS == 0) begin
                    hint_store = 1'b1;
                    hint_class = `CLPE_CLASS_RETAIN;
                end
            end
            `CLPE_HINT_IGN_HIT: begin
                if (SHORT_HINTS != 0) begin
                    hint_ok = kernel_mode;
                    hint_class = `CLPE_CLASS_REFILL;
                end
            end
            default: hint_store = 1'b0;
        endcase
    end

    // Fetch goes out only when safe; never traps, never writes state
    wire fetch_go = take && is_fetch && hint_ok
                    && !xlat_addr_error
                    && !xlat_uncached
                    && (!xlat_mapped || xlat_present);

    // One shift-add step; the 33-bit sum keeps the carry of the top word
    wire [32:0] add_sum = {1'b0, mul_acc_reg[63:32]} + {1'b0, mul_mcand_reg};
    wire [63:0] step_val = mul_acc_reg[0] ? {add_sum, mul_acc_reg[31:1]}
                                          : {1'b0, mul_acc_reg[63:1]};

    always @* begin
        mul_cnt_next = mul_cnt_reg;
        mul_acc_next = mul_acc_reg;
        if (take && is_umul) begin
            mul_cnt_next = MUL_CYCLES[5:0];
            mul_acc_next = {32'h0000_0000, source_b_value};
        end else if (mul_run) begin
            mul_cnt_next = mul_cnt_reg - 6'h01;
            mul_acc_next = step_val;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            mul_cnt_reg <= 6'h00;
            mul_mcand_reg <= 32'h0000_0000;
            mul_acc_reg <= 64'h0;
            product_bottom_word <= 32'h0000_0000;
            product_top_word <= 32'h0000_0000;
        end else begin
            mul_cnt_reg <= mul_cnt_next;
            if (take && is_umul) begin
                mul_mcand_reg <= source_a_value;
                mul_acc_reg <= mul_acc_next;
            end else if (mul_run) begin
                mul_acc_reg <= step_val;
            end
            // No overflow check anywhere in the multiply path
            if (mul_cnt_reg == 6'h01) begin
                product_bottom_word <= step_val[31:0];
                product_top_word <= step_val[63:32];
            end
        end
    end

    // Write-back, store, fetch and status updates
    reg        wb_en;
    reg [4:0]  wb_dst;
    reg [31:0] wb_val;
    always @* begin
        wb_en = 1'b0;
        wb_dst = dest_field;
        wb_val = 32'h0000_0000;
        if (take) begin
            if (is_nor) begin
                wb_en = 1'b1;
                wb_val = ~(source_a_value | source_b_value);
            end else if (is_or) begin
                wb_en = 1'b1;
                wb_val = source_a_value | source_b_value;
            end else if (is_ori) begin
                wb_en = 1'b1;
                wb_dst = source_b_field;
                wb_val = {16'h0000, imm} | source_a_value;
            end else if (is_mftop) begin
                wb_en = 1'b1;
                wb_val = product_top_word;
            end else if (is_mfbot) begin
                wb_en = 1'b1;
                wb_val = product_bottom_word;
            end
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            gr_we <= 1'b0;
            gr_waddr <= 5'h00;
            gr_wdata <= 32'h0000_0000;
            status_word_reg <= `CLPE_STATUS_RESET;
            link_flag <= 1'b0;
            reserved_instr_exc <= 1'b0;
            store_req <= 1'b0;
            store_addr <= 32'h0000_0000;
            store_data <= 32'h0000_0000;
            store_byte_en <= 4'h0;
            fetch_req <= 1'b0;
            fetch_addr <= 32'h0000_0000;
            fetch_for_store <= 1'b0;
            fetch_class <= `CLPE_CLASS_NORMAL;
            fetch_uncached <= 1'b0;
        end else begin
            gr_we <= wb_en && (wb_dst != 5'h00);
            gr_waddr <= wb_dst;
            gr_wdata <= wb_val;
            reserved_instr_exc <= take && is_restore && (HAS_RESTORE == 0);
            if (take && is_restore && HAS_RESTORE != 0) begin
                status_word_reg <= {status_word_reg[31:4], status_word_reg[5:2]};
                link_flag <= 1'b0;
            end
            store_req <= take && is_bstore;
            if (take && is_bstore) begin
                store_addr <= eff_addr;
                store_data <= {4{source_b_value[7:0]}};
                case (eff_addr[1:0])
                    2'h0: store_byte_en <= 4'h1;
                    2'h1: store_byte_en <= 4'h2;
                    2'h2: store_byte_en <= 4'h4;
                    default: store_byte_en <= 4'h8;
                endcase
            end
            // Fetch only drives its own port, no visible state changes
            fetch_req <= fetch_go;
            if (fetch_go) begin
                fetch_addr <= eff_addr;
                fetch_for_store <= hint_store;
                fetch_class <= hint_class;
                fetch_uncached <= xlat_uncached;
            end
        end
    end
endmodule // clpe_exec

// *** test/clpe_exec_properties.sv ***
// Checker for the execute slice; watches the ports of clpe_exec only
// Assumes clpe_map.vh on the include path and a bind to every clpe_exec
`timescale 1ns/1ps
`include "clpe_map.vh"
module clpe_exec_props #(parameter MUL_CYCLES = 32) (
    // Clock, reset and issue
    input wire        clk, srst, instr_valid, issue_stall,
    input wire [31:0] instr_word, source_a_value, source_b_value,
    input wire        xlat_mapped, xlat_present, xlat_uncached, xlat_addr_error,
    // Results
    input wire        gr_we, mul_busy, link_flag, reserved_instr_exc, store_req,
    input wire [4:0]  gr_waddr,
    input wire [31:0] gr_wdata, product_bottom_word, product_top_word, status_word_reg,
    input wire [31:0] store_addr, store_data, fetch_addr,
    input wire [3:0]  store_byte_en,
    input wire        fetch_req, fetch_for_store, fetch_uncached,
    input wire [1:0]  fetch_class
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire        take = instr_valid && !issue_stall;
    wire [5:0]  op   = instr_word[31:26];
    wire [5:0]  fn   = instr_word[5:0];
    wire        spec = take && op == `CLPE_OP_SPECIAL;
    wire        advance_fetch_op = take && op == `CLPE_OP_ADV_FETCH;
    wire        blk  = xlat_addr_error || xlat_uncached || (xlat_mapped && !xlat_present);
    wire [31:0] ea   = source_a_value + {{16{instr_word[15]}}, instr_word[15:0]};
    reg  [31:0] w_d, a_d, b_d, ea_d, sw_d;
    reg  [7:0]  busy_cnt;
    // Copies of the previous cycle and a run length of mul_busy
    always @(posedge clk) begin
        w_d <= instr_word;
        a_d <= source_a_value;
        b_d <= source_b_value;
        ea_d <= ea;
        sw_d <= status_word_reg;
        busy_cnt <= (srst || !mul_busy) ? 8'h00 : busy_cnt + 8'h01;
    end
    sequence s_mul_take; spec && fn == `CLPE_FN_UMUL; endsequence
    sequence s_mul_run; mul_busy && !reserved_instr_exc; endsequence
    sequence s_mul_done;
        !mul_busy && {product_top_word, product_bottom_word} ==
            {32'h0, $past(source_a_value, 33)} * {32'h0, $past(source_b_value, 33)};
    endsequence
    property p_mul; s_mul_take |=> s_mul_run ##32 s_mul_done; endproperty
    a_mul: assert property (p_mul) else $error("multiply product or timing wrong");
    property p_busy_len; mul_busy |-> busy_cnt < MUL_CYCLES; endproperty
    a_busy_len: assert property (p_busy_len) else $error("multiply busy too long");
    property p_stall;
        instr_valid && op == `CLPE_OP_SPECIAL && mul_busy &&
            (fn == `CLPE_FN_MFTOP || fn == `CLPE_FN_MFBOT) |-> issue_stall;
    endproperty
    a_stall: assert property (p_stall) else $error("product read not stalled");
    property p_nor;
        spec && fn == `CLPE_FN_NOR && instr_word[15:11] != 5'h00 |=>
            gr_we && gr_waddr == w_d[15:11] && gr_wdata == ~(a_d | b_d);
    endproperty
    a_nor: assert property (p_nor) else $error("nor result wrong");
    property p_or;
        spec && fn == `CLPE_FN_OR && instr_word[15:11] != 5'h00 |=>
            gr_we && gr_waddr == w_d[15:11] && gr_wdata == (a_d | b_d);
    endproperty
    a_or: assert property (p_or) else $error("or result wrong");
    property p_ori;
        take && op == `CLPE_OP_IMM_OR && instr_word[20:16] != 5'h00 |=>
            gr_we && gr_waddr == w_d[20:16] && gr_wdata == (a_d | {16'h0, w_d[15:0]});
    endproperty
    a_ori: assert property (p_ori) else $error("or immediate wrong");
    property p_zero; gr_we |-> gr_waddr != 5'h00; endproperty
    a_zero: assert property (p_zero) else $error("write to register zero");
    property p_fetch;
        advance_fetch_op && !blk |=> fetch_req && !fetch_uncached && fetch_addr == ea_d &&
            fetch_for_store == (w_d[16] && w_d[20:19] == 2'h0 && w_d[20:16] != 5'h03) &&
            fetch_class == (w_d[20:17] == 4'h2 ? 2'h1 : (w_d[20:17] == 4'h3 ? 2'h2 : 2'h0));
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch request wrong");
    property p_suppress; advance_fetch_op && blk |=> !fetch_req && !reserved_instr_exc; endproperty
    a_suppress: assert property (p_suppress) else $error("blocked fetch issued");
    property p_quiet; advance_fetch_op |=> !gr_we && !store_req && status_word_reg == sw_d; endproperty
    a_quiet: assert property (p_quiet) else $error("fetch changed state");
    property p_store;
        take && op == `CLPE_OP_BYTE_STORE |=> store_req && store_addr == ea_d &&
            store_data == {4{b_d[7:0]}} && store_byte_en == (4'h1 << ea_d[1:0]);
    endproperty
    a_store: assert property (p_store) else $error("byte store wrong");
    property p_restore;
        take && op == `CLPE_OP_SYSCOP && instr_word[25] && fn == `CLPE_FN_RESTORE |=>
            status_word_reg == {sw_d[31:4], sw_d[5:2]} && !link_flag && !reserved_instr_exc;
    endproperty
    a_restore: assert property (p_restore) else $error("status restore wrong");
endmodule // clpe_exec_props
bind clpe_exec clpe_exec_props #(.MUL_CYCLES(MUL_CYCLES)) clpe_exec_props_i (.*);

// *** test/clpe_exec_tb.sv ***
// Self-checking bench for the execute slice: drives issue, checks write-back,
// store and fetch ports against queued expectations
// Assumes clpe_exec with defaults and the checker bound beside it
`timescale 1ns/1ps
module clpe_exec_tb;
    logic        clk, srst, instr_valid, kernel_mode, issue_stall, gr_we, mul_busy, link_flag;
    logic        xlat_mapped, xlat_present, xlat_uncached, xlat_addr_error, reserved_instr_exc;
    logic        store_req, fetch_req, fetch_for_store, fetch_uncached;
    logic [31:0] instr_word, source_a_value, source_b_value, gr_wdata, product_bottom_word;
    logic [31:0] product_top_word, status_word_reg, store_addr, store_data, fetch_addr, a, b, ea;
    logic [4:0]  gr_waddr, rd;
    logic [3:0]  store_byte_en;
    logic [1:0]  fetch_class;
    logic [63:0] p;
    logic [36:0] q_gr[$];
    logic [67:0] q_st[$];
    logic [34:0] q_fe[$];
    integer      n_mismatch = 0, n_tests = 0, seed = 32'hbef2, i, j;
    clpe_exec #(.HAS_RESTORE(1), .SHORT_HINTS(0), .MUL_CYCLES(32)) clpe_exec_i (.*);
    always #10 clk = ~clk;
    task chk(input logic ok, input string m);
        n_tests = n_tests + 1;
        if (!ok) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task close_out;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Holds the instruction until taken; valid stays up for back-to-back issue
    task issue(input logic [31:0] w, x, y, input logic [4:0] r, input logic [31:0] v);
        integer k;
        begin
            if (r != 5'h00) q_gr.push_back({r, v});
            instr_valid <= 1'b1;
            instr_word <= w;
            source_a_value <= x;
            source_b_value <= y;
            k = 0;
            @(posedge clk);
            while (issue_stall !== 1'b0 && k < 100) begin
                k = k + 1;
                @(posedge clk);
            end
            if (k == 100) begin
                chk(1'b0, "stall never cleared");
                close_out;
            end
        end
    endtask
    task idle;
        instr_valid <= 1'b0;
        @(posedge clk);
    endtask
    // Output watcher: each result pulse takes the oldest expectation
    always @(posedge clk) if (!srst) begin
        if (gr_we === 1'b1) chk(q_gr.size() > 0 && {gr_waddr, gr_wdata} === q_gr.pop_front(), "write-back");
        if (store_req === 1'b1) chk(q_st.size() > 0 && {store_addr, store_data, store_byte_en} === q_st.pop_front(), "store");
        if (fetch_req === 1'b1) chk(q_fe.size() > 0 && {fetch_addr, fetch_for_store, fetch_class} === q_fe.pop_front() && fetch_uncached === 1'b0, "fetch");
        if (reserved_instr_exc !== 1'b0) chk(1'b0, "unexpected exception");
    end
    initial begin
        clk = 1'b0;
        srst = 1'b1;
        {instr_valid, kernel_mode, xlat_mapped, xlat_present, xlat_uncached, xlat_addr_error} = 6'h00;
        {instr_word, source_a_value, source_b_value} = 96'h0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        for (i = 0; i < 24; i++) begin
            a = $random(seed);
            b = $random(seed);
            rd = i[4:0];
            if (i % 3 == 2) issue({6'h0d, 5'h01, rd, b[15:0]}, a, b, rd, a | {16'h0, b[15:0]});
            else issue({11'h001, 5'h02, rd, 5'h00, (i % 3 == 0) ? 6'h27 : 6'h25}, a, b, rd, (i % 3 == 0) ? ~(a | b) : (a | b));
        end
        for (i = 0; i < 8; i++) begin
            a = $random(seed);
            b = $random(seed);
            ea = a + {{16{b[31]}}, b[31:16]};
            q_st.push_back({ea, {4{b[7:0]}}, 4'h1 << ea[1:0]});
            issue({6'h28, 5'h03, 5'h04, b[31:16]}, a, b, 5'h00, 32'h0);
        end
        for (i = 0; i < 32; i++) begin
            a = $random(seed);
            b = $random(seed);
            ea = a + {{16{b[31]}}, b[31:16]};
            xlat_mapped <= b[0];
            xlat_present <= 1'b1;
            kernel_mode <= b[1];
            q_fe.push_back({ea, i == 1 || i == 5 || i == 7, (i == 4 || i == 5) ? 2'h1 : (i == 6 || i == 7) ? 2'h2 : 2'h0});
            issue({6'h33, 5'h05, i[4:0], b[31:16]}, a, b, 5'h00, 32'h0);
        end
        for (j = 0; j < 3; j++) begin
            xlat_addr_error <= (j == 0);
            xlat_uncached <= (j == 1);
            xlat_mapped <= (j == 2);
            xlat_present <= (j != 2);
            issue({6'h33, 5'h05, 5'h00, 16'h8000}, $random(seed), 32'h0, 5'h00, 32'h0);
        end
        issue(32'h42000010, 32'h0, 32'h0, 5'h00, 32'h0);
        idle;
        chk(status_word_reg === 32'h0 && link_flag === 1'b0, "restore state");
        for (j = 0; j < 2; j++) begin
            a = j ? $random(seed) : 32'hffffffff;
            b = j ? $random(seed) : 32'hffffffff;
            p = {32'h0, a} * {32'h0, b};
            issue(32'h00850019, a, b, 5'h00, 32'h0);
            issue(32'h00002812, a, b, 5'h05, p[31:0]);
            issue(32'h00003010, a, b, 5'h06, p[63:32]);
            idle;
            chk({product_top_word, product_bottom_word} === p, "product");
        end
        repeat (4) idle;
        chk(q_gr.size() == 0 && q_st.size() == 0 && q_fe.size() == 0, "missing result");
        close_out;
    end
endmodule // clpe_exec_tb
